// ===== hw/lpm_pkg.sv
// Purpose: Shared constants and carrier types for the low-power mode controller.
// Assumes: One system clock at 125 MHz.
// Notes: Machine cycle length, resume length and the pin carrier type live here.
package lpm_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int MC_CLKS = 12;
    localparam int RESUME_MCS = 2;
    localparam logic [4:0] RESUME_CLKS = 5'(MC_CLKS * RESUME_MCS);
    localparam logic [7:0] ROM_RESET_DATA = 8'h00;
    localparam int ROM_ADDR_W = 12;

    typedef enum logic [1:0] {
        LPM_RUN = 2'b00,
        LPM_IDLE = 2'b01,
        LPM_PDOWN = 2'b11,
        LPM_RESUME = 2'b10
    } lpm_state_t;

    typedef struct packed {
        logic ale;
        logic prog_fetch_n;
        logic p0_oe;
        logic p2_addr_sel;
    } lpm_pins_t;
endpackage : lpm_pkg

// ===== hw/lpm_rom_verify.sv
// Purpose: ROM read-back path that puts the addressed byte on port 0.
// Assumes: Address inputs are synchronous; ROM contents arrive on rom_data_i from an outside ROM.
// Notes: Output is registered; port 0 relies on outside pull-ups when not enabled.
`timescale 1ns/1ps
module lpm_rom_verify #(
    parameter int AW = lpm_pkg::ROM_ADDR_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic verify_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [7:0] rom_data_i,
    output logic [AW-1:0] rom_addr_o,
    output logic [7:0] data_o,
    output logic data_oe_o
);
    logic [7:0] data_nxt;
    logic oe_nxt;

    assign rom_addr_o = addr_i;

    always_comb
    begin
        data_nxt = verify_i ? rom_data_i : lpm_pkg::ROM_RESET_DATA; // see [R15]
        oe_nxt = verify_i; // see [R15]
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            data_o <= lpm_pkg::ROM_RESET_DATA;
            data_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            data_o <= data_nxt;
            data_oe_o <= oe_nxt;
        end
    end

    a_rom_byte_out: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && verify_i |=> data_oe_o && data_o == $past(rom_data_i)) // see [R15]
        else $error("Addressed ROM byte not presented on port 0.");
endmodule : lpm_rom_verify

// ===== hw/lpm_ctrl.sv
// Purpose: Idle and power-down sequencing for an 8-bit microcontroller core.
// Assumes: Core requests arrive as one-cycle pulses synchronous to clk_sys_i.
// Notes: Reset out of idle lets the core run briefly with internal RAM writes blocked.
//
// What this block does
// [R01] Idle halts the core clock while peripherals keep their clock.
// [R02] Idle keeps on-chip RAM and special function registers unchanged.
// [R03] Idle ends on any enabled interrupt or on hardware reset.
// [R04] Reset out of idle lets the core resume up to two machine cycles.
// [R05] During that resumed run internal RAM writes are blocked, port writes are not.
// [R06] Software avoids port or external writes right after the idle instruction.
// [R07] Power-down stops the oscillator after the requesting instruction completes.
// [R08] Power-down keeps RAM and special function registers until exit.
// [R09] Only hardware reset leaves power-down; interrupts never wake it.
// [R10] Reset out of power-down reloads registers but leaves RAM untouched.
// [R11] The reset source holds reset until the oscillator has settled.
// [R12] Idle drives both strobes high; external mode floats port 0, port 2 shows address.
// [R13] Power-down drives both strobes low; external mode floats port 0.
// [R14] The tester places the ROM address on port 1 and low port 2 pins.
// [R15] During ROM read-back the addressed byte appears on port 0.
// [R16] An interrupt ending idle is serviced, then execution continues after idle.
`timescale 1ns/1ps
module lpm_ctrl #(
    parameter int AW = lpm_pkg::ROM_ADDR_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic hw_reset_i,
    input wire logic idle_req_i,
    input wire logic pdown_req_i,
    input wire logic irq_pending_i,
    input wire logic ext_mem_i,
    input wire logic verify_i,
    input wire logic [7:0] p1_addr_i,
    input wire logic [3:0] p2_addr_i,
    input wire logic [7:0] rom_data_i,
    output logic core_run_o,
    output logic periph_run_o,
    output logic osc_en_o,
    output logic ram_wr_block_o,
    output logic special_function_registers_reset_o,
    output logic irq_take_o,
    output logic ale_o,
    output logic program_fetch_strobe_n_o,
    output logic p0_oe_n_o,
    output logic p2_addr_sel_o,
    output logic [AW-1:0] rom_addr_o,
    output logic [7:0] p0_data_o,
    output logic p0_data_oe_o
);
    lpm_pkg::lpm_state_t state_r, state_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    lpm_pkg::lpm_pins_t pins_r, pins_nxt;
    logic core_run_nxt, osc_nxt, blk_nxt, regs_rst_nxt, take_nxt;
    logic [4:0] blk_len_r, blk_len_nxt;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        take_nxt = 1'b0;
        regs_rst_nxt = 1'b0;
        case (state_r)
            lpm_pkg::LPM_RUN:
            begin
                if (hw_reset_i)
                    regs_rst_nxt = 1'b1;
                else if (pdown_req_i)
                    state_nxt = lpm_pkg::LPM_PDOWN; // see [R07]
                else if (idle_req_i)
                    state_nxt = lpm_pkg::LPM_IDLE; // see [R01]
            end
            lpm_pkg::LPM_IDLE:
            begin
                if (hw_reset_i)
                begin
                    // The core runs on briefly, so RAM must be guarded here.
                    state_nxt = lpm_pkg::LPM_RESUME; // see [R04]
                    cnt_nxt = lpm_pkg::RESUME_CLKS - 5'h01;
                end
                else if (irq_pending_i)
                begin
                    state_nxt = lpm_pkg::LPM_RUN; // see [R03]
                    take_nxt = 1'b1; // see [R16]
                end
            end
            lpm_pkg::LPM_PDOWN:
            begin
                // Interrupts are ignored; only reset restarts the oscillator.
                if (hw_reset_i)
                begin
                    state_nxt = lpm_pkg::LPM_RUN; // see [R09]
                    regs_rst_nxt = 1'b1; // see [R10]
                end
            end
            lpm_pkg::LPM_RESUME:
            begin
                if (cnt_r == 5'h00)
                begin
                    state_nxt = lpm_pkg::LPM_RUN;
                    regs_rst_nxt = 1'b1; // see [R04]
                end
                else
                    cnt_nxt = cnt_r - 5'h01;
            end
            default:
                state_nxt = lpm_pkg::LPM_RUN;
        endcase
    end

    always_comb
    begin
        // Core stopped in idle and power-down keeps RAM and registers frozen.
        core_run_nxt = (state_nxt == lpm_pkg::LPM_RUN) ||
            (state_nxt == lpm_pkg::LPM_RESUME); // see [R02] [R08]
        osc_nxt = state_nxt != lpm_pkg::LPM_PDOWN; // see [R07]
        blk_nxt = state_nxt == lpm_pkg::LPM_RESUME; // see [R05]
        pins_nxt = '{ale: 1'b1, prog_fetch_n: 1'b1, p0_oe: 1'b1, p2_addr_sel: ext_mem_i};
        if (state_nxt == lpm_pkg::LPM_IDLE)
            pins_nxt = '{ale: 1'b1, prog_fetch_n: 1'b1, p0_oe: !ext_mem_i,
                p2_addr_sel: ext_mem_i}; // see [R12]
        else if (state_nxt == lpm_pkg::LPM_PDOWN)
            pins_nxt = '{ale: 1'b0, prog_fetch_n: 1'b0, p0_oe: !ext_mem_i,
                p2_addr_sel: 1'b0}; // see [R13]
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= lpm_pkg::LPM_RUN;
            cnt_r <= 5'h00;
            pins_r <= '{ale: 1'b1, prog_fetch_n: 1'b1, p0_oe: 1'b1, p2_addr_sel: 1'b0};
            core_run_o <= 1'b1;
            osc_en_o <= 1'b1;
            ram_wr_block_o <= 1'b0;
            special_function_registers_reset_o <= 1'b1;
            irq_take_o <= 1'b0;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pins_r <= pins_nxt;
            core_run_o <= core_run_nxt;
            osc_en_o <= osc_nxt;
            ram_wr_block_o <= blk_nxt;
            special_function_registers_reset_o <= regs_rst_nxt;
            irq_take_o <= take_nxt;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            periph_run_o <= 1'b1;
        else if (ce_i)
            periph_run_o <= osc_nxt; // see [R01]
    end

    always_comb
    begin
        ale_o = pins_r.ale;
        program_fetch_strobe_n_o = pins_r.prog_fetch_n;
        p0_oe_n_o = !pins_r.p0_oe;
        p2_addr_sel_o = pins_r.p2_addr_sel;
    end

    lpm_rom_verify #(
        .AW(AW)
    ) u_rom_verify (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .verify_i(verify_i),
        .addr_i({p2_addr_i, p1_addr_i}), // see [R14]
        .rom_data_i(rom_data_i),
        .rom_addr_o(rom_addr_o),
        .data_o(p0_data_o),
        .data_oe_o(p0_data_oe_o)
    );

    a_idle_core_stop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_r == lpm_pkg::LPM_IDLE |-> !core_run_o && periph_run_o) // see [R01]
        else $error("Core not halted or peripherals stopped in idle.");
    a_idle_irq_wake: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && state_r == lpm_pkg::LPM_IDLE && irq_pending_i && !hw_reset_i
        |=> core_run_o && irq_take_o) // see [R03] [R16]
        else $error("Enabled interrupt did not end idle.");

    // Counts consecutive blocked cycles, so the resume length needs no long repetition.
    always_comb
    begin
        blk_len_nxt = ram_wr_block_o ? blk_len_r + 5'h01 : 5'h00;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            blk_len_r <= 5'h00;
        else if (ce_i)
            blk_len_r <= blk_len_nxt;
    end

    a_resume_start: assert property (@(posedge clk_sys_i) disable iff (rst_i || !ce_i)
        state_r == lpm_pkg::LPM_IDLE && hw_reset_i
        |=> ram_wr_block_o && core_run_o) // see [R04] [R05]
        else $error("Reset out of idle did not start a guarded resumed run.");
    a_resume_bound: assert property (@(posedge clk_sys_i) disable iff (rst_i || !ce_i)
        ram_wr_block_o |-> blk_len_r < lpm_pkg::RESUME_CLKS) // see [R04]
        else $error("Resumed run after idle reset longer than two machine cycles.");
    a_resume_length: assert property (@(posedge clk_sys_i) disable iff (rst_i || !ce_i)
        $fell(ram_wr_block_o) |-> blk_len_r == lpm_pkg::RESUME_CLKS) // see [R04] [R05]
        else $error("Resumed run after idle reset not exactly two machine cycles.");
    a_pdown_osc_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_r == lpm_pkg::LPM_PDOWN |-> !osc_en_o && !core_run_o) // see [R07] [R08]
        else $error("Oscillator or core running in power-down.");
    a_pdown_no_irq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && state_r == lpm_pkg::LPM_PDOWN && !hw_reset_i
        |=> state_r == lpm_pkg::LPM_PDOWN) // see [R09]
        else $error("Power-down left without hardware reset.");
    a_pdown_reg_reload: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && state_r == lpm_pkg::LPM_PDOWN && hw_reset_i
        |=> special_function_registers_reset_o && osc_en_o) // see [R10]
        else $error("Reset out of power-down did not reload registers.");
    a_idle_strobes: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_r == lpm_pkg::LPM_IDLE |-> ale_o && program_fetch_strobe_n_o) // see [R12]
        else $error("Strobes not high in idle.");
    a_pdown_strobes: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        state_r == lpm_pkg::LPM_PDOWN |-> !ale_o && !program_fetch_strobe_n_o
        && !p2_addr_sel_o) // see [R13]
        else $error("Strobes not low in power-down.");
endmodule : lpm_ctrl

// ===== test/lpm_rom_model.sv
// Purpose: ROM array and port 0 pull-ups standing outside the controller.
// Assumes: The ROM answers combinationally to the address it is given.
// Notes: Contents are a fixed pattern, so the bench can predict every byte.
`timescale 1ns/1ps
module lpm_rom_model (
    input wire logic [11:0] rom_addr_i,
    input wire logic [7:0] p0_data_i,
    input wire logic p0_data_oe_i,
    output logic [7:0] rom_data_o,
    output logic [7:0] p0_pin_o
);
    assign rom_data_o = rom_addr_i[7:0] + {rom_addr_i[11:8], 4'h5};
    // The pull-ups lift an undriven port, so a float never shows stale data.
    assign p0_pin_o = p0_data_oe_i ? p0_data_i : 8'hff;
endmodule : lpm_rom_model

// ===== test/testbench.sv
// Purpose: Self-checking bench for idle, power-down and ROM read-back.
// Assumes: Inputs change by non-blocking assignment at the rising clock edge.
// Notes: Clock enable is dropped once in idle to show that it holds the controller in idle despite a pending interrupt.
`timescale 1ns/1ps
module testbench;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic hw_reset_i = 1'b0;
    logic idle_req_i = 1'b0;
    logic pdown_req_i = 1'b0;
    logic irq_pending_i = 1'b0;
    logic ext_mem_i = 1'b1;
    logic verify_i = 1'b0;
    logic [7:0] p1_addr_i = 8'h00;
    logic [3:0] p2_addr_i = 4'h0;
    logic [7:0] rom_data_i, p0_data_o, p0_pin;
    logic [11:0] rom_addr_o;
    logic core_run_o, periph_run_o, osc_en_o, ram_wr_block_o, regs_reset, irq_take_o;
    logic ale_o, program_fetch_strobe_n_o, p0_oe_n_o, p2_addr_sel_o, p0_data_oe_o;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    lpm_ctrl dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
        .hw_reset_i(hw_reset_i), .idle_req_i(idle_req_i), .pdown_req_i(pdown_req_i),
        .irq_pending_i(irq_pending_i), .ext_mem_i(ext_mem_i), .verify_i(verify_i),
        .p1_addr_i(p1_addr_i), .p2_addr_i(p2_addr_i), .rom_data_i(rom_data_i),
        .core_run_o(core_run_o), .periph_run_o(periph_run_o), .osc_en_o(osc_en_o),
        .ram_wr_block_o(ram_wr_block_o), .special_function_registers_reset_o(regs_reset),
        .irq_take_o(irq_take_o), .ale_o(ale_o),
        .program_fetch_strobe_n_o(program_fetch_strobe_n_o), .p0_oe_n_o(p0_oe_n_o),
        .p2_addr_sel_o(p2_addr_sel_o), .rom_addr_o(rom_addr_o), .p0_data_o(p0_data_o),
        .p0_data_oe_o(p0_data_oe_o));

    lpm_rom_model rom_u (.rom_addr_i(rom_addr_o), .p0_data_i(p0_data_o),
        .p0_data_oe_i(p0_data_oe_o), .rom_data_o(rom_data_i), .p0_pin_o(p0_pin));

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick;
        @(posedge clk_sys_i);
        #1;
    endtask : tick

    // One-cycle request; bits are hardware reset, power-down, idle, interrupt.
    task automatic req(input logic [3:0] m);
        @(posedge clk_sys_i);
        {hw_reset_i, pdown_req_i, idle_req_i, irq_pending_i} <= m;
        @(posedge clk_sys_i);
        {hw_reset_i, pdown_req_i, idle_req_i, irq_pending_i} <= 4'h0;
        #1;
    endtask : req

    task automatic idle_irq_wake;
        req(4'h2);
        chk({core_run_o, periph_run_o, ale_o, program_fetch_strobe_n_o}, 4'h7);
        chk({p0_oe_n_o, p2_addr_sel_o}, 2'h3);
        req(4'h1);
        chk({core_run_o, irq_take_o}, 2'h3);
        tick();
        chk(irq_take_o, 1'h0);
    endtask : idle_irq_wake

    task automatic ce_freeze;
        req(4'h2);
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        irq_pending_i <= 1'b1;
        repeat (3) tick();
        chk({core_run_o, irq_take_o}, 2'h0);
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        tick();
        chk({core_run_o, irq_take_o}, 2'h3);
        @(posedge clk_sys_i);
        irq_pending_i <= 1'b0;
        tick();
        chk(irq_take_o, 1'h0);
    endtask : ce_freeze

    task automatic idle_reset_resume;
        @(posedge clk_sys_i);
        ext_mem_i <= 1'b0;
        req(4'h2);
        chk({p0_oe_n_o, p2_addr_sel_o}, 2'h0);
        req(4'h8);
        chk({ram_wr_block_o, core_run_o, regs_reset}, 3'h6);
        repeat (23) tick();
        chk({ram_wr_block_o, core_run_o, regs_reset}, 3'h6);
        tick();
        chk({ram_wr_block_o, regs_reset}, 2'h1);
    endtask : idle_reset_resume

    task automatic pdown_cycle;
        @(posedge clk_sys_i);
        ext_mem_i <= 1'b1;
        req(4'h4);
        chk({osc_en_o, core_run_o, periph_run_o}, 3'h0);
        chk({ale_o, program_fetch_strobe_n_o, p0_oe_n_o, p2_addr_sel_o}, 4'h2);
        req(4'h3);
        chk({osc_en_o, core_run_o, irq_take_o}, 3'h0);
        req(4'h8);
        chk({osc_en_o, core_run_o, regs_reset}, 3'h7);
    endtask : pdown_cycle

    task automatic rom_readback(input logic [7:0] lo, input logic [3:0] hi);
        @(posedge clk_sys_i);
        verify_i <= 1'b1;
        p1_addr_i <= lo;
        p2_addr_i <= hi;
        tick();
        chk(p0_oe_n_o === 1'b0 ? p0_pin : 8'h00, 8'(lo + {hi, 4'h5}));
        @(posedge clk_sys_i);
        verify_i <= 1'b0;
        tick();
        chk(p0_pin, 8'hff);
    endtask : rom_readback

    task automatic summarize;
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            summarize();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        tick();
        idle_irq_wake();
        ce_freeze();
        idle_reset_resume();
        pdown_cycle();
        rom_readback(8'h5a, 4'h3);
        rom_readback(8'hff, 4'hf);
        summarize();
    end
endmodule : testbench
